// ===== cpu_core_datapath.sv
`timescale 1ns/10ps
// Overview of operation
// - Next instruction word is fetched while the current one executes.
// - Thirty-two eight-bit working registers, read and written each cycle.
// - Two operands read, computed and written back in one cycle.
// - Four register pairs act as sixteen-bit data-space pointers.
// - Each pointer also addresses program memory for constant tables.
// - Register-register, register-immediate and single-register ALU ops.
// - Decoder routes opcodes to arithmetic, logic or bit functions.
// - Arithmetic results update the status flags.
// - Sixteen-bit instruction words; jumps and calls take two words.
// - Calls and interrupt entry push the return address to SRAM.
// - Stack pointer is readable and writable through I/O space.
// - Each source has its own vector; lowest vector wins.
// - Global interrupt enable bit lives in the status register.
// - 64 I/O addresses, also at data addresses 0x20 to 0x5F.
// - Global enable is bit 7, cleared on entry, set on return from interrupt.
// - Return address push subtracts two, return adds two.
module cpu_core_datapath #(
  parameter int IRQ_N = 8,
  parameter logic [15:0] RAM_END = 16'h00FF
) (
  input wire logic i_clk, // CPU clock
  input wire logic i_rst_n, // Synchronous reset, active low
  output logic [15:0] o_pmem_addr, // Program word address
  input wire logic [15:0] i_pmem_data, // Program word, same cycle
  output cpu_core_pkg::dbus_t o_dbus, // Data SRAM and I/O strobes
  output logic [5:0] o_io_addr, // I/O register number
  input wire logic [7:0] i_mem_rdata, // SRAM read data, same cycle
  input wire logic [7:0] i_io_rdata, // I/O read data, same cycle
  input wire logic [IRQ_N-1:0] i_irq, // Enabled pending requests
  output logic [IRQ_N-1:0] o_irq_ack, // One-hot taken pulse
  output logic [7:0] o_status, // Status register
  output logic [15:0] o_stack_pointer // Stack pointer
);
  if (IRQ_N < 1 || IRQ_N > 32) begin : g_bad_irq
    $error("IRQ_N must be 1 to 32");
  end

  typedef struct packed {
    cpu_core_pkg::state_t state;
    logic [15:0] fa;
    logic [15:0] ir;
    logic ir_ok;
    logic [15:0] ret;
    logic [15:0] tgt;
    logic [15:0] stack_pointer;
    logic [7:0] sreg;
    logic [4:0] dst;
    cpu_core_pkg::src_t src;
    logic reti;
    logic [cpu_core_pkg::REG_COUNT-1:0][7:0] rf;
    cpu_core_pkg::dbus_t dbus;
    logic [5:0] io_addr;
    logic [31:0] ack;
  } core_t;

  core_t s_r;
  core_t s_nxt;

  // ------------------------------------------------------------
  // ALU
  // ------------------------------------------------------------
  function automatic cpu_core_pkg::alu_out_t alu_f(input logic [4:0] op,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] sr);
    cpu_core_pkg::alu_out_t o;
    logic [8:0] w;
    logic [4:0] h;
    logic ci;
    logic v;
    logic upd;
    o.sreg = sr;
    o.wr = 1'b1;
    upd = 1'b1;
    v = 1'b0;
    h = 5'h00;
    w = {1'b0, a};
    ci = (op == cpu_core_pkg::A_ADC || op == cpu_core_pkg::A_SBC) &
         sr[cpu_core_pkg::F_C];
    unique case (op)
      cpu_core_pkg::A_ADD, cpu_core_pkg::A_ADC: begin
        w = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        v = (a[7] == b[7]) && (w[7] != a[7]);
      end
      cpu_core_pkg::A_SUB, cpu_core_pkg::A_SBC, cpu_core_pkg::A_CMP,
      cpu_core_pkg::A_NEG: begin
        if (op == cpu_core_pkg::A_NEG) begin
          w = 9'h000 - {1'b0, a};
          h = 5'h00 - {1'b0, a[3:0]};
          v = (a == 8'h80);
        end else begin
          w = {1'b0, a} - {1'b0, b} - {8'h00, ci};
          h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
          v = (a[7] != b[7]) && (w[7] != a[7]);
        end
        o.wr = (op != cpu_core_pkg::A_CMP);
      end
      cpu_core_pkg::A_AND: w = {1'b0, a & b};
      cpu_core_pkg::A_OR: w = {1'b0, a | b};
      cpu_core_pkg::A_XOR: w = {1'b0, a ^ b};
      cpu_core_pkg::A_MOV: begin
        w = {1'b0, b};
        upd = 1'b0;
      end
      cpu_core_pkg::A_INC: begin
        w = {sr[cpu_core_pkg::F_C], a + 8'h01};
        v = (a == 8'h7F);
      end
      cpu_core_pkg::A_DEC: begin
        w = {sr[cpu_core_pkg::F_C], a - 8'h01};
        v = (a == 8'h80);
      end
      cpu_core_pkg::A_COM: w = {1'b1, ~a};
      cpu_core_pkg::A_LSR: w = {a[0], 1'b0, a[7:1]};
      cpu_core_pkg::A_ROR: w = {a[0], sr[cpu_core_pkg::F_C], a[7:1]};
      cpu_core_pkg::A_ASR: w = {a[0], a[7], a[7:1]};
      cpu_core_pkg::A_SWAP: begin
        w = {1'b0, a[3:0], a[7:4]};
        upd = 1'b0;
      end
      default: begin
        o.wr = 1'b0;
        upd = 1'b0;
      end
    endcase
    if (op == cpu_core_pkg::A_LSR || op == cpu_core_pkg::A_ROR ||
        op == cpu_core_pkg::A_ASR) begin
      v = w[7] ^ w[8];
    end
    o.res = w[7:0];
    if (upd) begin
      if (op[4:2] != 3'h1 || op == cpu_core_pkg::A_CMP) begin
        o.sreg[cpu_core_pkg::F_H] = h[4];
        o.sreg[cpu_core_pkg::F_C] = w[8];
      end
      if (op == cpu_core_pkg::A_INC || op == cpu_core_pkg::A_DEC) begin
        o.sreg[cpu_core_pkg::F_H] = sr[cpu_core_pkg::F_H];
      end
      o.sreg[cpu_core_pkg::F_N] = w[7];
      o.sreg[cpu_core_pkg::F_Z] = (w[7:0] == 8'h00) &
          ((op != cpu_core_pkg::A_SBC) | sr[cpu_core_pkg::F_Z]);
      o.sreg[cpu_core_pkg::F_V] = v;
      o.sreg[cpu_core_pkg::F_S] = w[7] ^ v;
    end
    return o;
  endfunction : alu_f

  // ------------------------------------------------------------
  // Decode and operand selection
  // ------------------------------------------------------------
  logic [1:0] cls;
  logic [4:0] d_idx;
  logic [4:0] ptr_lo;
  logic [15:0] ptr_val;
  logic is_acc;
  logic is_store;
  logic [15:0] acc_addr;
  logic [4:0] acc_reg;
  logic [5:0] acc_io;
  logic [4:0] alu_d;
  logic [4:0] alu_op;
  cpu_core_pkg::alu_out_t alu_o;
  logic [4:0] irq_idx;
  logic take;
  logic [15:0] irq_vec;

  assign cls = s_r.ir[15:14];
  assign d_idx = s_r.ir[9:5];
  assign ptr_lo = cpu_core_pkg::PTR_BASE + {2'b00, s_r.ir[1:0], 1'b0};
  assign ptr_val = {s_r.rf[ptr_lo + 5'h01], s_r.rf[ptr_lo]};
  assign is_acc = (cls == cpu_core_pkg::CLS_CTL) && (s_r.ir[13] ||
      s_r.ir[12:10] == cpu_core_pkg::C_LD || s_r.ir[12:10] == cpu_core_pkg::C_ST);
  assign is_store = s_r.ir[13] ? s_r.ir[12] : s_r.ir[12:10] == cpu_core_pkg::C_ST;
  assign acc_addr = s_r.ir[13] ? cpu_core_pkg::IO_BASE + {10'h000, s_r.ir[5:0]}
                               : ptr_val;
  assign acc_reg = s_r.ir[13] ? s_r.ir[10:6] : d_idx;
  assign acc_io = 6'(acc_addr - cpu_core_pkg::IO_BASE);
  assign take = s_r.state == cpu_core_pkg::ST_EXEC && s_r.ir_ok &&
                s_r.sreg[cpu_core_pkg::F_I] && (|i_irq);
  assign irq_vec = cpu_core_pkg::RESET_VECTOR + 16'h0001 + {11'h000, irq_idx};

  always_comb begin
    irq_idx = 5'h00;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (i_irq[i]) irq_idx = 5'(i);
    end
  end

  always_comb begin
    alu_d = d_idx;
    alu_op = {1'b0, s_r.ir[13:10]};
    if (cls == cpu_core_pkg::CLS_IMM) begin
      alu_d = {1'b1, s_r.ir[11:8]};
      alu_op = cpu_core_pkg::IMM_OP[s_r.ir[13:12]];
    end else if (cls == cpu_core_pkg::CLS_ONE) begin
      alu_op = {1'b1, s_r.ir[13:10]};
    end
    alu_o = alu_f(alu_op, s_r.rf[alu_d],
                  cls == cpu_core_pkg::CLS_IMM ? s_r.ir[7:0]
                                               : s_r.rf[s_r.ir[4:0]],
                  s_r.sreg);
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.dbus.mem_we = 1'b0;
    s_nxt.dbus.mem_re = 1'b0;
    s_nxt.dbus.io_we = 1'b0;
    s_nxt.dbus.io_re = 1'b0;
    s_nxt.ack = '0;
    unique case (s_r.state)
      cpu_core_pkg::ST_EXEC: begin
        s_nxt.ir = i_pmem_data;
        s_nxt.ir_ok = 1'b1;
        s_nxt.fa = s_r.fa + 16'h0001;
        if (take) begin
          // Held word is re-executed after return, so it is the return point
          s_nxt.ret = s_r.fa - 16'h0001;
          s_nxt.tgt = irq_vec;
          s_nxt.sreg[cpu_core_pkg::F_I] = 1'b0;
          s_nxt.ack[irq_idx] = 1'b1;
          s_nxt.dbus.mem_we = 1'b1;
          s_nxt.dbus.addr = s_r.stack_pointer;
          s_nxt.dbus.wdata = s_nxt.ret[7:0];
          s_nxt.state = cpu_core_pkg::ST_PUSH;
        end else if (s_r.ir_ok) begin
          unique case (cls)
            cpu_core_pkg::CLS_RR, cpu_core_pkg::CLS_IMM: begin
              if (alu_o.wr) s_nxt.rf[alu_d] = alu_o.res;
              s_nxt.sreg = alu_o.sreg;
            end
            cpu_core_pkg::CLS_ONE: begin
              unique case (s_r.ir[13:10])
                cpu_core_pkg::B_TSTORE:
                  s_nxt.sreg[cpu_core_pkg::F_T] = s_r.rf[d_idx][s_r.ir[2:0]];
                cpu_core_pkg::B_TLOAD:
                  s_nxt.rf[d_idx][s_r.ir[2:0]] = s_r.sreg[cpu_core_pkg::F_T];
                cpu_core_pkg::B_SET: s_nxt.rf[d_idx][s_r.ir[2:0]] = 1'b1;
                cpu_core_pkg::B_CLR: s_nxt.rf[d_idx][s_r.ir[2:0]] = 1'b0;
                cpu_core_pkg::B_SKIPSET, cpu_core_pkg::B_SKIPCLR:
                  if (s_r.rf[d_idx][s_r.ir[2:0]] == ~s_r.ir[10])
                    s_nxt.ir_ok = 1'b0;
                cpu_core_pkg::B_FSET: s_nxt.sreg[s_r.ir[2:0]] = 1'b1;
                cpu_core_pkg::B_FCLR: s_nxt.sreg[s_r.ir[2:0]] = 1'b0;
                default: begin
                  s_nxt.rf[d_idx] = alu_o.res;
                  s_nxt.sreg = alu_o.sreg;
                end
              endcase
            end
            cpu_core_pkg::CLS_CTL: begin
              if (is_acc && is_store) begin
                if (acc_addr < cpu_core_pkg::IO_BASE) begin
                  s_nxt.rf[acc_addr[4:0]] = s_r.rf[acc_reg];
                end else if (acc_addr <= cpu_core_pkg::IO_LAST) begin
                  unique case (acc_io)
                    cpu_core_pkg::IO_SP_LO:
                      s_nxt.stack_pointer[7:0] = s_r.rf[acc_reg];
                    cpu_core_pkg::IO_SP_HI:
                      s_nxt.stack_pointer[15:8] = s_r.rf[acc_reg];
                    cpu_core_pkg::IO_STATUS: s_nxt.sreg = s_r.rf[acc_reg];
                    default: begin
                      s_nxt.dbus.io_we = 1'b1;
                      s_nxt.io_addr = acc_io;
                      s_nxt.dbus.wdata = s_r.rf[acc_reg];
                    end
                  endcase
                end else begin
                  s_nxt.dbus.mem_we = 1'b1;
                  s_nxt.dbus.addr = acc_addr;
                  s_nxt.dbus.wdata = s_r.rf[acc_reg];
                end
              end else if (is_acc) begin
                s_nxt.ret = acc_addr;
                s_nxt.dst = acc_reg;
                s_nxt.io_addr = acc_io;
                s_nxt.dbus.addr = acc_addr;
                if (acc_addr < cpu_core_pkg::IO_BASE) begin
                  s_nxt.src = cpu_core_pkg::SRC_REG;
                end else if (acc_addr > cpu_core_pkg::IO_LAST) begin
                  s_nxt.src = cpu_core_pkg::SRC_MEM;
                  s_nxt.dbus.mem_re = 1'b1;
                end else if (acc_io >= cpu_core_pkg::IO_SP_LO) begin
                  s_nxt.src = cpu_core_pkg::SRC_CORE;
                end else begin
                  s_nxt.src = cpu_core_pkg::SRC_IO;
                  s_nxt.dbus.io_re = 1'b1;
                end
                s_nxt.ir = s_r.ir;
                s_nxt.fa = s_r.fa;
                s_nxt.state = cpu_core_pkg::ST_LOAD;
              end
              if (is_acc && !s_r.ir[13] && s_r.ir[2]) begin
                {s_nxt.rf[ptr_lo + 5'h01], s_nxt.rf[ptr_lo]} =
                  ptr_val + 16'h0001;
              end
              if (!is_acc) begin
                unique case (s_r.ir[12:10])
                  cpu_core_pkg::C_JMP: begin
                    s_nxt.fa = i_pmem_data;
                    s_nxt.ir_ok = 1'b0;
                  end
                  cpu_core_pkg::C_CALL: begin
                    s_nxt.ret = s_r.fa + 16'h0001;
                    s_nxt.tgt = i_pmem_data;
                    s_nxt.dbus.mem_we = 1'b1;
                    s_nxt.dbus.addr = s_r.stack_pointer;
                    s_nxt.dbus.wdata = s_nxt.ret[7:0];
                    s_nxt.state = cpu_core_pkg::ST_PUSH;
                  end
                  cpu_core_pkg::C_RET, cpu_core_pkg::C_RETI: begin
                    s_nxt.dbus.mem_re = 1'b1;
                    s_nxt.dbus.addr = s_r.stack_pointer + 16'h0001;
                    s_nxt.reti = s_r.ir[10];
                    s_nxt.state = cpu_core_pkg::ST_POP_HI;
                  end
                  cpu_core_pkg::C_LPM: begin
                    s_nxt.fa = {1'b0, ptr_val[15:1]};
                    s_nxt.tgt = ptr_val;
                    s_nxt.ret = s_r.fa;
                    s_nxt.dst = d_idx;
                    s_nxt.state = cpu_core_pkg::ST_LPM;
                  end
                  default: ;
                endcase
              end
            end
          endcase
        end
      end
      cpu_core_pkg::ST_LOAD: begin
        s_nxt.ir = i_pmem_data;
        s_nxt.ir_ok = 1'b1;
        s_nxt.fa = s_r.fa + 16'h0001;
        s_nxt.state = cpu_core_pkg::ST_EXEC;
        unique case (s_r.src)
          cpu_core_pkg::SRC_REG: s_nxt.rf[s_r.dst] = s_r.rf[s_r.ret[4:0]];
          cpu_core_pkg::SRC_CORE: begin
            unique case (s_r.io_addr)
              cpu_core_pkg::IO_SP_LO: s_nxt.rf[s_r.dst] = s_r.stack_pointer[7:0];
              cpu_core_pkg::IO_SP_HI: s_nxt.rf[s_r.dst] = s_r.stack_pointer[15:8];
              default: s_nxt.rf[s_r.dst] = s_r.sreg;
            endcase
          end
          cpu_core_pkg::SRC_IO: s_nxt.rf[s_r.dst] = i_io_rdata;
          cpu_core_pkg::SRC_MEM: s_nxt.rf[s_r.dst] = i_mem_rdata;
        endcase
      end
      cpu_core_pkg::ST_LPM: begin
        s_nxt.rf[s_r.dst] = s_r.tgt[0] ? i_pmem_data[15:8] : i_pmem_data[7:0];
        s_nxt.fa = s_r.ret;
        s_nxt.ir_ok = 1'b0;
        s_nxt.state = cpu_core_pkg::ST_EXEC;
      end
      cpu_core_pkg::ST_PUSH: begin
        s_nxt.dbus.mem_we = 1'b1;
        s_nxt.dbus.addr = s_r.stack_pointer - 16'h0001;
        s_nxt.dbus.wdata = s_r.ret[15:8];
        s_nxt.stack_pointer = s_r.stack_pointer - cpu_core_pkg::CALL_STEP;
        s_nxt.fa = s_r.tgt;
        s_nxt.ir_ok = 1'b0;
        s_nxt.state = cpu_core_pkg::ST_EXEC;
      end
      cpu_core_pkg::ST_POP_HI: begin
        s_nxt.ret[15:8] = i_mem_rdata;
        s_nxt.dbus.mem_re = 1'b1;
        s_nxt.dbus.addr = s_r.stack_pointer + cpu_core_pkg::CALL_STEP;
        s_nxt.state = cpu_core_pkg::ST_POP_LO;
      end
      cpu_core_pkg::ST_POP_LO: begin
        s_nxt.fa = {s_r.ret[15:8], i_mem_rdata};
        s_nxt.stack_pointer = s_r.stack_pointer + cpu_core_pkg::CALL_STEP;
        if (s_r.reti) s_nxt.sreg[cpu_core_pkg::F_I] = 1'b1;
        s_nxt.ir_ok = 1'b0;
        s_nxt.state = cpu_core_pkg::ST_EXEC;
      end
      default: s_nxt.state = cpu_core_pkg::ST_EXEC;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.fa <= cpu_core_pkg::RESET_VECTOR;
      s_r.stack_pointer <= RAM_END;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_pmem_addr = s_r.fa;
  assign o_dbus = s_r.dbus;
  assign o_io_addr = s_r.io_addr;
  assign o_irq_ack = s_r.ack[IRQ_N-1:0];
  assign o_status = s_r.sreg;
  assign o_stack_pointer = s_r.stack_pointer;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic ex_rr;
  assign ex_rr = s_r.state == cpu_core_pkg::ST_EXEC && s_r.ir_ok && !take &&
                 cls == cpu_core_pkg::CLS_RR && alu_o.wr;

  fetch_advance_a: assert property (
      ex_rr |=> o_pmem_addr == $past(o_pmem_addr) + 16'h0001)
    else $error("fetch did not advance");
  rr_writeback_a: assert property (
      ex_rr |=> s_r.rf[$past(d_idx)] == $past(alu_o.res))
    else $error("result not written back");
  zero_flag_a: assert property (
      (ex_rr && s_r.ir[13:10] == 4'h0) |=>
      s_r.sreg[cpu_core_pkg::F_Z] == (s_r.rf[$past(d_idx)] == 8'h00))
    else $error("zero flag wrong after add");
  push_sequence_a: assert property (
      (s_r.state == cpu_core_pkg::ST_PUSH) |->
      o_dbus.mem_we && o_dbus.addr == s_r.stack_pointer ##1
      o_dbus.mem_we && o_dbus.wdata == $past(s_r.ret[15:8]) &&
      s_r.stack_pointer == $past(s_r.stack_pointer) - 16'h0002)
    else $error("return address push wrong");
  pop_step_a: assert property (
      (s_r.state == cpu_core_pkg::ST_POP_LO) |=>
      s_r.stack_pointer == $past(s_r.stack_pointer) + 16'h0002 &&
      !s_r.ir_ok)
    else $error("pop did not add two");
  irq_entry_a: assert property (
      take |=> !s_r.sreg[cpu_core_pkg::F_I] ##1
      o_pmem_addr == $past(irq_vec, 2))
    else $error("interrupt entry wrong");
  irq_priority_a: assert property (
      take |=> o_irq_ack == ($past(i_irq) & (~$past(i_irq) + 1'b1)))
    else $error("wrong interrupt served");
  reti_enable_a: assert property (
      (s_r.state == cpu_core_pkg::ST_POP_LO && s_r.reti) |=>
      s_r.sreg[cpu_core_pkg::F_I])
    else $error("return did not re-enable");
  jump_flush_a: assert property (
      (s_r.state == cpu_core_pkg::ST_EXEC && s_r.ir_ok && !take &&
      s_r.ir[15:10] == 6'h30) |=>
      !s_r.ir_ok && o_pmem_addr == $past(i_pmem_data))
    else $error("jump did not flush");
  io_window_a: assert property (
      o_dbus.io_we |-> o_io_addr < 6'h3D)
    else $error("core register leaked to I/O bus");
  lpm_addr_a: assert property (
      (s_r.state == cpu_core_pkg::ST_LPM) |->
      o_pmem_addr == {1'b0, s_r.tgt[15:1]})
    else $error("table read address wrong");

  irq_taken_c: cover property (take ##1 s_r.state == cpu_core_pkg::ST_PUSH);
  table_read_c: cover property (s_r.state == cpu_core_pkg::ST_LPM);
  reti_done_c: cover property (s_r.state == cpu_core_pkg::ST_POP_LO && s_r.reti);
  io_load_c: cover property (s_r.state == cpu_core_pkg::ST_LOAD &&
      s_r.src == cpu_core_pkg::SRC_IO);
endmodule : cpu_core_datapath

// ===== cpu_core_pkg.sv
package cpu_core_pkg;
  // ------------------------------------------------------------
  // Address map and reset values
  // ------------------------------------------------------------
  localparam int REG_COUNT = 32;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] IO_LAST = 16'h005F;
  localparam logic [5:0] IO_SP_LO = 6'h3D;
  localparam logic [5:0] IO_SP_HI = 6'h3E;
  localparam logic [5:0] IO_STATUS = 6'h3F;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] CALL_STEP = 16'h0002;
  localparam logic [4:0] PTR_BASE = 5'h1A;
  localparam int F_C = 0;
  localparam int F_Z = 1;
  localparam int F_N = 2;
  localparam int F_V = 3;
  localparam int F_S = 4;
  localparam int F_H = 5;
  localparam int F_T = 6;
  localparam int F_I = 7;
  // ------------------------------------------------------------
  // Instruction classes and function codes
  // ------------------------------------------------------------
  localparam logic [1:0] CLS_RR = 2'h0;
  localparam logic [1:0] CLS_IMM = 2'h1;
  localparam logic [1:0] CLS_ONE = 2'h2;
  localparam logic [1:0] CLS_CTL = 2'h3;
  localparam logic [4:0] A_ADD = 5'h00;
  localparam logic [4:0] A_ADC = 5'h01;
  localparam logic [4:0] A_SUB = 5'h02;
  localparam logic [4:0] A_SBC = 5'h03;
  localparam logic [4:0] A_AND = 5'h04;
  localparam logic [4:0] A_OR = 5'h05;
  localparam logic [4:0] A_XOR = 5'h06;
  localparam logic [4:0] A_MOV = 5'h07;
  localparam logic [4:0] A_CMP = 5'h08;
  localparam logic [4:0] A_INC = 5'h10;
  localparam logic [4:0] A_DEC = 5'h11;
  localparam logic [4:0] A_COM = 5'h12;
  localparam logic [4:0] A_NEG = 5'h13;
  localparam logic [4:0] A_LSR = 5'h14;
  localparam logic [4:0] A_ROR = 5'h15;
  localparam logic [4:0] A_ASR = 5'h16;
  localparam logic [4:0] A_SWAP = 5'h17;
  localparam logic [3:0][4:0] IMM_OP = {A_OR, A_AND, A_SUB, A_MOV};
  localparam logic [3:0] B_TSTORE = 4'h8;
  localparam logic [3:0] B_TLOAD = 4'h9;
  localparam logic [3:0] B_SET = 4'hA;
  localparam logic [3:0] B_CLR = 4'hB;
  localparam logic [3:0] B_SKIPSET = 4'hC;
  localparam logic [3:0] B_SKIPCLR = 4'hD;
  localparam logic [3:0] B_FSET = 4'hE;
  localparam logic [3:0] B_FCLR = 4'hF;
  localparam logic [2:0] C_JMP = 3'h0;
  localparam logic [2:0] C_CALL = 3'h1;
  localparam logic [2:0] C_RET = 3'h2;
  localparam logic [2:0] C_RETI = 3'h3;
  localparam logic [2:0] C_LD = 3'h4;
  localparam logic [2:0] C_ST = 3'h5;
  localparam logic [2:0] C_LPM = 3'h6;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_EXEC, ST_LOAD, ST_LPM, ST_PUSH, ST_POP_HI, ST_POP_LO
  } state_t;
  typedef enum logic [1:0] {SRC_REG, SRC_CORE, SRC_IO, SRC_MEM} src_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic mem_we;
    logic mem_re;
    logic io_we;
    logic io_re;
  } dbus_t;
  typedef struct packed {
    logic [7:0] res;
    logic [7:0] sreg;
    logic wr;
  } alu_out_t;
endpackage : cpu_core_pkg

// ===== mem_model.sv
`timescale 1ns/10ps
module mem_model (
  input wire logic i_clk, // CPU clock
  input wire logic [15:0] i_pmem_addr, // Program word address
  output logic [15:0] o_pmem_data, // Program word
  input wire cpu_core_pkg::dbus_t i_dbus, // Data strobes
  input wire logic [5:0] i_io_addr, // I/O number
  output logic [7:0] o_mem_rdata, // SRAM data
  output logic [7:0] o_io_rdata // I/O data
);
  logic [15:0] rom [256];
  logic [7:0] ram [256];
  logic [7:0] io [64];
  logic [7:0] ram_q;
  assign ram_q = ram[i_dbus.addr[7:0]];
  assign o_pmem_data = rom[i_pmem_addr[7:0]];
  // Unselected reads give inverted data, so a stale sample cannot match
  assign o_mem_rdata = i_dbus.mem_re ? ram_q : ~ram_q;
  assign o_io_rdata = i_dbus.io_re ? io[i_io_addr] : ~io[i_io_addr];
  always @(posedge i_clk) begin
    if (i_dbus.mem_we) ram[i_dbus.addr[7:0]] <= i_dbus.wdata;
    if (i_dbus.io_we) io[i_io_addr] <= i_dbus.wdata;
  end
endmodule : mem_model

// ===== tb_cpu_core_datapath.sv
`timescale 1ns/10ps
module tb_cpu_core_datapath;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_irq = 8'h00;
  logic [15:0] pa, pd, sp;
  cpu_core_pkg::dbus_t db;
  logic [5:0] ioa;
  logic [7:0] md, iod, ack, st;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int t;
  // Function, a, b, result, {Z C expected, Z C mask}
  logic [31:0] rows [11] = '{32'h0_0F_01_10_3, 32'h0_FF_01_00_F,
    32'h2_05_05_00_B, 32'h2_00_01_FF_7, 32'h4_F0_0F_00_A,
    32'h5_50_0A_5A_2, 32'h6_FF_FF_00_A, 32'h7_00_33_33_0,
    32'h8_10_20_10_7, 32'h1_01_01_03_3, 32'h3_10_01_0F_3};
  // Subroutine: table read, pointer store/load, stack and I/O reads, skip
  logic [15:0] sub_rom [21] = '{16'h4E21, 16'h4F01, 16'hDA82, 16'hF520,
    16'h4A80, 16'h4B00, 16'hD684, 16'h4C80, 16'h4D00, 16'hD2A1, 16'hF561,
    16'hF6A2, 16'hE5BD, 16'hF5A3, 16'h82C0, 16'hB2C1, 16'h82C0, 16'hF5A4,
    16'hE5E0, 16'hF5E5, 16'hC800};
  always #25 i_clk = ~i_clk;
  cpu_core_datapath i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .o_pmem_addr(pa), .i_pmem_data(pd), .o_dbus(db), .o_io_addr(ioa),
    .i_mem_rdata(md), .i_io_rdata(iod), .i_irq(i_irq), .o_irq_ack(ack),
    .o_status(st), .o_stack_pointer(sp));
  mem_model i_mem (.i_clk(i_clk), .i_pmem_addr(pa), .o_pmem_data(pd),
    .i_dbus(db), .i_io_addr(ioa), .o_mem_rdata(md), .o_io_rdata(iod));
  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask : tick
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    for (int k = 0; k < 256; k++) i_mem.rom[k] = 16'h0000;
    i_mem.rom[1] = 16'h0010;
    i_mem.rom[0] = 16'hC000;
    i_mem.rom[2] = 16'hCC00;
    i_mem.rom[3] = 16'hCC00;
    for (int i = 0; i < 11; i++) begin
      i_mem.rom[16+4*i] = {8'h40, rows[i][27:20]};
      i_mem.rom[17+4*i] = {8'h41, rows[i][19:12]};
      i_mem.rom[18+4*i] = {2'b00, rows[i][31:28], 10'h211};
      i_mem.rom[19+4*i] = 16'hF400 | 16'(i);
    end
    i_mem.rom[60] = 16'hC400;
    i_mem.rom[61] = 16'h0070;
    i_mem.rom[62] = 16'hB807;
    i_mem.rom[63] = 16'hC000;
    i_mem.rom[64] = 16'h003F;
    foreach (sub_rom[k]) i_mem.rom[112+k] = sub_rom[k];
    i_mem.rom[144] = 16'hA55A;
    repeat (20) tick();
    check(pa, 16'h0000);
    check({8'h00, st}, 16'h0000);
    check(sp, 16'h00FF);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      for (t = 0; t < 20 && db.io_we !== 1'b1; t++) tick();
      if (i > 0) check(16'(t), 16'h0003);
      check({8'h00, db.wdata}, {8'h00, rows[i][11:4]});
      check({10'h000, ioa}, 16'(i));
      check(16'(st[1:0] & rows[i][1:0]), 16'(rows[i][3:0] >> 2));
      tick();
    end
    $display("test alu done");
    for (t = 0; t < 20 && db.mem_we !== 1'b1; t++) tick();
    check(db.addr, 16'h00FF);
    check({8'h00, db.wdata}, 16'h003E);
    tick();
    check({db.addr[7:0], db.wdata}, 16'hFE00);
    check(pa, 16'h0070);
    check(sp, 16'h00FD);
    for (t = 0; t < 60 && pa !== 16'h003E; t++) tick();
    tick();
    check(sp, 16'h00FF);
    check({8'h00, i_mem.io[32]}, 16'h00A5);
    check({8'h00, i_mem.io[33]}, 16'h00A5);
    check({8'h00, i_mem.io[34]}, 16'h0081);
    check({8'h00, i_mem.io[35]}, 16'h00FD);
    check({8'h00, i_mem.io[36]}, 16'h00FE);
    check({8'h00, i_mem.io[37]}, 16'h00A5);
    $display("test call done");
    for (t = 0; t < 20 && st[7] !== 1'b1; t++) tick();
    @(negedge i_clk);
    i_irq = 8'h06;
    for (t = 0; t < 20 && ack === 8'h00; t++) tick();
    check({ack, 7'h00, st[7]}, 16'h0200);
    @(negedge i_clk);
    i_irq = 8'h04;
    for (t = 0; t < 20 && pa !== 16'h0002; t++) tick();
    check(pa, 16'h0002);
    for (t = 0; t < 30 && st[7] !== 1'b1; t++) tick();
    check({15'h0000, st[7]}, 16'h0001);
    for (t = 0; t < 30 && ack === 8'h00; t++) tick();
    check({8'h00, ack}, 16'h0004);
    @(negedge i_clk);
    i_irq = 8'h00;
    $display("test irq done");
    finish_test();
  end
endmodule : tb_cpu_core_datapath
